// ==== common/alert_mask_cfg.svh ====
// constants for the alert mask gating block
`ifndef ALERT_MASK_CFG_SVH
`define ALERT_MASK_CFG_SVH
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_ALERT_MASK   8'h1B
`define CODE_STS_CURRENT 8'h7B
`define CODE_STS_INPUT   8'h7C
`define CODE_STS_TEMP    8'h7D
`define CODE_STS_CML     8'h7E
`define CODE_STS_MISC    8'h7F
`define CODE_STS_VENDOR  8'h80
`define IMPL_CURRENT     8'hF0
`define IMPL_INPUT       8'hF8
`define IMPL_TEMP        8'hF0
`define IMPL_CML         8'hFB
`define IMPL_MISC        8'h01
`define IMPL_VENDOR      8'hF0
`define MASK_RESET       8'h00
`define GROUP_COUNT      6
`define GROUP_NONE       3'h7
`endif

// ==== common/alert_mask_pkg.sv ====
// types shared by the alert mask gating block
package alert_mask_pkg;
  // one status byte per group, current group in the low byte
  typedef struct packed {
    logic [7:0] vendor;
    logic [7:0] misc;
    logic [7:0] cml;
    logic [7:0] temp;
    logic [7:0] input_grp;
    logic [7:0] current;
  } status_set_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] code;
    logic [7:0] arg;
    logic [7:0] data;
  } cmd_t;

  typedef struct packed {
    logic       valid;
    logic       err;
    logic [7:0] data;
  } rsp_t;

  typedef logic [5:0][7:0] group_bytes_t;
endpackage

// ==== rtl/alert_mask_gating.sv ====
// alert mask registers, sticky status and alert line drive
`timescale 1ns/1ps
`default_nettype none
`include "alert_mask_cfg.svh"
module alert_mask_gating (
  input  wire logic                        CLK_SYS,
  input  wire logic                        ARST_N,
  input  wire logic                        CE,
  input  wire alert_mask_pkg::cmd_t        CMD,
  input  wire alert_mask_pkg::status_set_t STATUS_SET,
  output var  alert_mask_pkg::rsp_t        RSP,
  output logic                             ALERT_LINE_O,
  output logic                             ALERT_LINE_OE
);
  import alert_mask_pkg::*;

  // reset release through two flops
  logic rst_meta;
  logic rst_n;
  logic next_rst_meta;
  logic next_rst_n;

  // only the second flop reads the first one
  always_comb begin
    next_rst_meta = 1'b1;
    next_rst_n    = rst_meta;
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= next_rst_meta;
      rst_n    <= next_rst_n;
    end
  end

  // status code to group index, GROUP_NONE when not a status code
  function automatic logic [2:0] group_of(input logic [7:0] code);
    logic [7:0] diff;
    diff = code - `CODE_STS_CURRENT;
    if (code >= `CODE_STS_CURRENT && code <= `CODE_STS_VENDOR)
      group_of = diff[2:0];
    else
      group_of = `GROUP_NONE;
  endfunction

  // bits that exist in each group; the rest read as zero
  function automatic logic [7:0] impl_bits(input logic [2:0] idx);
    case (idx)
      3'h0:    impl_bits = `IMPL_CURRENT;
      3'h1:    impl_bits = `IMPL_INPUT;
      3'h2:    impl_bits = `IMPL_TEMP;
      3'h3:    impl_bits = `IMPL_CML;
      3'h4:    impl_bits = `IMPL_MISC;
      3'h5:    impl_bits = `IMPL_VENDOR;
      default: impl_bits = 8'h00;
    endcase
  endfunction

  group_bytes_t mask;
  group_bytes_t status;
  group_bytes_t next_mask;
  group_bytes_t next_status;
  group_bytes_t set_bytes;
  rsp_t         next_rsp;
  logic         next_alert;
  logic         any_unmasked;
  logic [2:0]   grp;
  logic         take;
  logic         is_mask_wr;
  logic         is_clear;

  assign set_bytes = group_bytes_t'(STATUS_SET);
  assign take      = CE && CMD.valid;
  assign is_mask_wr = take && CMD.write && CMD.code == `CMD_ALERT_MASK
                      && group_of(CMD.arg) != `GROUP_NONE;
  assign is_clear  = take && CMD.write && CMD.code == `CMD_CLEAR_FAULTS;

  always_comb begin
    next_mask   = mask;
    next_status = status;
    next_rsp    = '0;
    grp         = `GROUP_NONE;
    if (take) begin
      next_rsp.valid = 1'b1;
      if (CMD.code == `CMD_ALERT_MASK) begin
        // status code picks the mask byte
        grp = group_of(CMD.arg);
        if (grp == `GROUP_NONE) begin
          next_rsp.err = 1'b1;
        end else if (is_mask_wr) begin
          next_mask[grp] = CMD.data & impl_bits(grp);
        end else begin
          next_rsp.data = mask[grp];
        end
      end else if (CMD.code == `CMD_CLEAR_FAULTS) begin
        next_rsp.err = !CMD.write;
      end else begin
        grp = group_of(CMD.code);
        if (grp == `GROUP_NONE || CMD.write)
          next_rsp.err = 1'b1;
        else
          next_rsp.data = status[grp];
      end
    end
    // clear all status, then new events win
    if (is_clear)
      next_status = '0;
    for (int i = 0; i < `GROUP_COUNT; i++) begin
      next_status[i] = next_status[i]
                       | (set_bytes[i] & impl_bits(3'(i)));
    end
  end

  // zero mask bit lets a status bit through
  always_comb begin
    any_unmasked = 1'b0;
    for (int i = 0; i < `GROUP_COUNT; i++) begin
      any_unmasked = any_unmasked | (|(status[i] & ~mask[i]));
    end
    // alert follows the gated status level
    next_alert = any_unmasked;
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      mask          <= {`GROUP_COUNT{`MASK_RESET}};
      status        <= '0;
      RSP           <= '0;
      ALERT_LINE_O  <= 1'b0;
      ALERT_LINE_OE <= 1'b0;
    end else if (CE) begin
      mask          <= next_mask;
      status        <= next_status;
      RSP           <= next_rsp;
      ALERT_LINE_O  <= 1'b0;
      ALERT_LINE_OE <= next_alert;
    end
  end

  // checks on command and alert paths
  sequence s_mask_write;
    CE && CMD.valid && CMD.write && CMD.code == `CMD_ALERT_MASK
      && CMD.arg >= `CODE_STS_CURRENT && CMD.arg <= `CODE_STS_VENDOR;
  endsequence

  sequence s_ack_ok;
    RSP.valid && !RSP.err;
  endsequence

  chk_alert_gating: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    CE |=> ALERT_LINE_OE == $past(any_unmasked))
    else $error("alert enable does not follow unmasked status");

  // held while unmasked bit stays set
  chk_alert_hold: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (CE && any_unmasked) ##1 (CE && any_unmasked) |=> ALERT_LINE_OE [*1])
    else $error("alert released with unmasked status set");

  // mask write lands and is acknowledged
  chk_mask_store: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    s_mask_write |=> s_ack_ok
      and mask[$past(grp)] == ($past(CMD.data) & impl_bits($past(grp))))
    else $error("mask byte not stored in selected group");

  // clear with no new events empties status
  chk_clear_all: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (is_clear && STATUS_SET == '0)
      |=> (status == '0) and (CE |=> !ALERT_LINE_OE))
    else $error("clear-faults left status or alert");

  // event in the clearing cycle survives
  chk_set_wins: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (is_clear && set_bytes[0] != 8'h00)
      |=> status[0] == ($past(set_bytes[0]) & `IMPL_CURRENT))
    else $error("event lost in clearing cycle");

  // current group keeps bits 7..4 only
  chk_current_bits: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (mask[0] & ~`IMPL_CURRENT) == 8'h00)
    else $error("current mask holds unused bits");

  // input group keeps bits 7..3 only
  chk_input_bits: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (CE && set_bytes[1][3]) |=> status[1][3] && !status[1][2])
    else $error("input group bit 3 not captured or bit 2 set");

  // temperature group keeps bits 7..4 only
  chk_temp_bits: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    ((mask[2] | status[2]) & ~`IMPL_TEMP) == 8'h00)
    else $error("temperature group holds unused bits");

  chk_cml_bits: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (CE && set_bytes[3][0]) |=> status[3][0] && !status[3][2] && !mask[3][2])
    else $error("comm/logic group bits wrong");

  // misc group has only bit 0
  chk_misc_bits: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (status[4][0] && !mask[4][0]) |-> any_unmasked && status[4][7:1] == 7'h00)
    else $error("misc group gating wrong");

  // vendor group keeps bits 7..4 only
  chk_vendor_bits: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    ((mask[5] | status[5]) & ~`IMPL_VENDOR) == 8'h00)
    else $error("vendor group holds unused bits");

  chk_rsp_answer: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    take |=> RSP.valid)
    else $error("taken request got no response");

  chk_rsp_single: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (CE && !take) |=> !RSP.valid)
    else $error("response valid without a request");

  chk_bad_group: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (take && CMD.code == `CMD_ALERT_MASK && group_of(CMD.arg) == `GROUP_NONE)
      |=> RSP.err && $stable(mask))
    else $error("bad group code not refused");

  // mask read returns the stored byte
  chk_mask_read: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (take && !CMD.write && CMD.code == `CMD_ALERT_MASK
      && group_of(CMD.arg) != `GROUP_NONE) |=> RSP.data == $past(mask[grp]))
    else $error("mask read returned wrong byte");

  // low enable freezes state and outputs
  chk_freeze: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    !CE |=> $stable(mask) && $stable(status) && $stable(RSP)
      && $stable(ALERT_LINE_OE))
    else $error("state moved while clock enable low");

  // every set bit masked keeps line free
  chk_masked_quiet: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (CE && (status & ~mask) == '0) |=> !ALERT_LINE_OE)
    else $error("alert pulled with every set bit masked");

  chk_status_sticky: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (CE && !is_clear) |=> (status & $past(status)) == $past(status))
    else $error("status bit dropped without clear");

  chk_clear_refuse: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (take && CMD.code == `CMD_CLEAR_FAULTS && !CMD.write) |=> RSP.err)
    else $error("read of clear-faults not refused");

  chk_current_pull: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (CE && status[0][5] && !mask[0][5]) |=> ALERT_LINE_OE)
    else $error("current warning did not pull alert");

  chk_input_pull: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (CE && status[1][3] && !mask[1][3]) |=> ALERT_LINE_OE)
    else $error("insufficient input did not pull alert");

  chk_temp_pull: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (CE && status[2][6] && !mask[2][6]) |=> ALERT_LINE_OE)
    else $error("temperature warning did not pull alert");

  // unmasked other comm fault pulls line
  chk_cml_pull: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (CE && status[3][1] && !mask[3][1]) |=> ALERT_LINE_OE)
    else $error("comm/logic fault did not pull alert");

  chk_misc_pull: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (CE && status[4][0] && !mask[4][0]) |=> ALERT_LINE_OE)
    else $error("misc bit did not pull alert");

  chk_vendor_pull: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (CE && status[5][4] && !mask[5][4]) |=> ALERT_LINE_OE)
    else $error("short-circuit fault did not pull alert");

endmodule
`default_nettype wire

// ==== sim/alert_mask_gating_test.sv ====
// self-checking bench for the alert mask gating block
`timescale 1ns/1ps
`default_nettype none
`include "alert_mask_cfg.svh"
module alert_mask_gating_test;
  import alert_mask_pkg::*;
  logic        clk_sys;
  logic        arst_n;
  logic        ce;
  cmd_t        cmd;
  status_set_t status_set;
  rsp_t        rsp;
  logic        alert_line_o;
  logic        alert_line_oe;
  logic        alert_seen;
  int          fails;
  int          n_compared;
  rsp_t        got;
  logic [7:0]  impl [6];
  logic [7:0]  grp;
  logic [7:0]  bitv;

  alert_mask_gating u_alert_mask_gating (
    .CLK_SYS(clk_sys), .ARST_N(arst_n), .CE(ce), .CMD(cmd),
    .STATUS_SET(status_set), .RSP(rsp), .ALERT_LINE_O(alert_line_o),
    .ALERT_LINE_OE(alert_line_oe));
  pmbus_host_model u_pmbus_host_model (
    .clk(clk_sys), .rsp(rsp), .alert_line_o(alert_line_o),
    .alert_line_oe(alert_line_oe), .cmd(cmd), .alert_seen(alert_seen));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [7:0] got_v, input logic [7:0] exp_v);
    n_compared++;
    if (got_v !== exp_v) begin
      fails++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got_v,
               exp_v);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    fails = 0;
    n_compared = 0;
    ce = 1'b1;
    status_set = '0;
    arst_n = 1'b0;
    impl = '{`IMPL_CURRENT, `IMPL_INPUT, `IMPL_TEMP, `IMPL_CML, `IMPL_MISC,
             `IMPL_VENDOR};
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    idle(3);
    check({7'h0, alert_seen}, 8'h00);
    for (int g = 0; g < 6; g++) begin
      grp = 8'(`CODE_STS_CURRENT + g);
      u_pmbus_host_model.xfer(1'b0, `CMD_ALERT_MASK, grp, 8'h00, got);
      check(got.data, `MASK_RESET);
      u_pmbus_host_model.xfer(1'b1, `CMD_ALERT_MASK, grp, 8'hFF, got);
      check({7'h0, got.valid}, 8'h01);
      check({7'h0, got.err}, 8'h00);
      u_pmbus_host_model.xfer(1'b0, `CMD_ALERT_MASK, grp, 8'h00, got);
      check(got.data, impl[g]);
    end
    for (int g = 0; g < 6; g++) begin
      grp = 8'(`CODE_STS_CURRENT + g);
      for (int b = 0; b < 8; b++) begin
        bitv = 8'(1 << b);
        u_pmbus_host_model.xfer(1'b1, `CMD_ALERT_MASK, grp, 8'hFF, got);
        @(posedge clk_sys);
        status_set <= status_set_t'(48'(bitv) << (8 * g));
        @(posedge clk_sys);
        status_set <= '0;
        idle(2);
        check({7'h0, alert_seen}, 8'h00);
        u_pmbus_host_model.xfer(1'b0, grp, 8'h00, 8'h00, got);
        check(got.data, impl[g] & bitv);
        // unmasking a standing bit must raise the line
        u_pmbus_host_model.xfer(1'b1, `CMD_ALERT_MASK, grp, ~bitv, got);
        idle(2);
        check({7'h0, alert_seen}, 8'((impl[g] & bitv) != 8'h00));
        u_pmbus_host_model.clear_faults(got);
        idle(2);
        check({7'h0, alert_seen}, 8'h00);
      end
    end
    u_pmbus_host_model.xfer(1'b0, `CMD_CLEAR_FAULTS, 8'h00, 8'h00, got);
    check({7'h0, got.err}, 8'h01);
    u_pmbus_host_model.xfer(1'b1, `CMD_ALERT_MASK, 8'h7A, 8'h00, got);
    check({7'h0, got.err}, 8'h01);
    u_pmbus_host_model.xfer(1'b1, `CODE_STS_CURRENT, 8'h00, 8'hFF, got);
    check({7'h0, got.err}, 8'h01);
    u_pmbus_host_model.xfer(1'b0, 8'h20, 8'h00, 8'h00, got);
    check({7'h0, got.err}, 8'h01);
    // event and clear in one cycle: the event stays
    fork
      u_pmbus_host_model.clear_faults(got);
      begin
        @(posedge clk_sys);
        status_set <= status_set_t'(48'h80);
        @(posedge clk_sys);
        status_set <= '0;
      end
    join
    u_pmbus_host_model.xfer(1'b0, `CODE_STS_CURRENT, 8'h00, 8'h00, got);
    check(got.data, 8'h80);
    idle(2);
    check({7'h0, alert_seen}, 8'h01);
    u_pmbus_host_model.clear_faults(got);
    idle(2);
    check({7'h0, alert_seen}, 8'h00);
    // set request while frozen is lost
    @(posedge clk_sys);
    ce <= 1'b0;
    status_set <= status_set_t'(48'h80);
    @(posedge clk_sys);
    status_set <= '0;
    ce <= 1'b1;
    idle(3);
    check({7'h0, alert_seen}, 8'h00);
    // reset in mid-run with a standing unmasked event
    @(posedge clk_sys);
    status_set <= status_set_t'(48'h80);
    @(posedge clk_sys);
    status_set <= '0;
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    idle(3);
    check({7'h0, alert_seen}, 8'h00);
    u_pmbus_host_model.xfer(1'b0, `CMD_ALERT_MASK, `CODE_STS_CURRENT,
                            8'h00, got);
    check(got.data, `MASK_RESET);
    u_pmbus_host_model.xfer(1'b0, `CODE_STS_CURRENT, 8'h00, 8'h00, got);
    check(got.data, 8'h00);
    end_sim;
  end

  initial begin
    #500_000;
    fails++;
    end_sim;
  end
endmodule
`default_nettype wire

// ==== sim/pmbus_host_model.sv ====
// host controller model: issues commands and watches the alert line
`timescale 1ns/1ps
`default_nettype none
`include "alert_mask_cfg.svh"
module pmbus_host_model (
  input  wire logic                 clk,
  input  wire alert_mask_pkg::rsp_t rsp,
  input  wire logic                 alert_line_o,
  input  wire logic                 alert_line_oe,
  output var  alert_mask_pkg::cmd_t cmd,
  output logic                      alert_seen
);
  import alert_mask_pkg::*;
  // pulled up; open drain only pulls low while enabled
  assign alert_seen = ~(alert_line_oe ? alert_line_o : 1'b1);
  initial cmd = '0;
  task automatic xfer(input logic wr, input logic [7:0] code,
                      input logic [7:0] arg, input logic [7:0] data,
                      output rsp_t got);
    @(posedge clk);
    cmd <= '{1'b1, wr, code, arg, data};
    @(posedge clk);
    // idle bus shows no stale request
    cmd <= '{1'b0, ~wr, ~code, ~arg, ~data};
    #1;
    got = rsp;
  endtask
  task automatic clear_faults(output rsp_t got);
    xfer(1'b1, `CMD_CLEAR_FAULTS, 8'h00, 8'h00, got);
  endtask
endmodule
`default_nettype wire
